/* File: fault_chk.sv */
/*
 * concurrent checks on the ports of the switch protection block.
 * assumes it is bound onto switch_fault_protection; one clock domain.
 */
module fault_chk (
    input  wire logic          SYS_CLK,
    input  wire logic          RESETN,
    input  prot_pkg::ch_cfg_t  CH_CFG [prot_pkg::NUM_CH],
    input  wire logic          CMP_SUPPLY_HIGH,
    input  wire logic          CMP_SUPPLY_LOW,
    input  wire logic          SUPPLY_HIGH_CHECK_OFF,
    input  wire logic          STATUS_READ,
    input  prot_pkg::ch_stat_t CH_STAT [prot_pkg::NUM_CH],
    input  wire logic          SUPPLY_HIGH_FAULT,
    input  wire logic          SUPPLY_LOW_FAULT,
    input  wire logic          FAULT_FLAG_N,
    input  wire logic          SENSE_VALID_STROBE_N,
    input  wire logic          SENSE_BLANK
);
    timeunit 1ns;
    timeprecision 1ps;
    import prot_pkg::*;
    logic any_win;
    logic all_off;
    assign any_win = CH_STAT[0].window_active || CH_STAT[1].window_active;
    assign all_off = !CH_STAT[0].drive_on && !CH_STAT[1].drive_on;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    property p_blank;
        (SENSE_VALID_STROBE_N == any_win) && (SENSE_BLANK == any_win);
    endproperty
    a_blank: assert property (p_blank) else $error("sense blanking differs from window state");
    property p_oc;
        $rose(CH_STAT[0].current_trip) |-> !CH_STAT[0].drive_on && (CH_CFG[0].retry_enable || !FAULT_FLAG_N);
    endproperty
    a_oc: assert property (p_oc) else $error("overcurrent left channel on or line high");
    property p_sc;
        $rose(CH_STAT[0].short_trip) |-> !CH_STAT[0].drive_on && (CH_CFG[0].retry_enable || !FAULT_FLAG_N);
    endproperty
    a_sc: assert property (p_sc) else $error("short left channel on or line high");
    property p_sh;
        (CMP_SUPPLY_HIGH && !SUPPLY_HIGH_CHECK_OFF) [*7] |-> all_off && !FAULT_FLAG_N && SUPPLY_HIGH_FAULT;
    endproperty
    a_sh: assert property (p_sh) else $error("supply high not acted on");
    property p_sh_warn;
        (CMP_SUPPLY_HIGH && SUPPLY_HIGH_CHECK_OFF) [*7] |-> SUPPLY_HIGH_FAULT;
    endproperty
    a_sh_warn: assert property (p_sh_warn) else $error("supply high warning missing");
    property p_sl;
        CMP_SUPPLY_LOW [*7] |-> all_off && !FAULT_FLAG_N && SUPPLY_LOW_FAULT;
    endproperty
    a_sl: assert property (p_sl) else $error("supply low not acted on");
    property p_sh_clr;
        $fell(SUPPLY_HIGH_FAULT) |-> $past(STATUS_READ);
    endproperty
    a_sh_clr: assert property (p_sh_clr) else $error("supply high flag cleared without read");
    property p_sl_clr;
        $fell(SUPPLY_LOW_FAULT) |-> $past(STATUS_READ) || CH_CFG[0].channel_drive_request
            || CH_CFG[1].channel_drive_request;
    endproperty
    a_sl_clr: assert property (p_sl_clr) else $error("supply low flag cleared without cause");
    c_oc: cover property ($rose(CH_STAT[0].current_trip));
    c_sl: cover property ($rose(SUPPLY_LOW_FAULT));
    c_win: cover property ($rose(CH_STAT[0].window_active));
endmodule
bind switch_fault_protection fault_chk i_chk (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .CH_CFG(CH_CFG),
    .CMP_SUPPLY_HIGH(CMP_SUPPLY_HIGH), .CMP_SUPPLY_LOW(CMP_SUPPLY_LOW), .STATUS_READ(STATUS_READ),
    .SUPPLY_HIGH_CHECK_OFF(SUPPLY_HIGH_CHECK_OFF), .CH_STAT(CH_STAT), .SUPPLY_HIGH_FAULT(SUPPLY_HIGH_FAULT),
    .SUPPLY_LOW_FAULT(SUPPLY_LOW_FAULT), .FAULT_FLAG_N(FAULT_FLAG_N),
    .SENSE_VALID_STROBE_N(SENSE_VALID_STROBE_N), .SENSE_BLANK(SENSE_BLANK));

/* File: load_model.sv */
/*
 * behavioural loads on both switch channels.
 * assumes comparators only see current while the channel drives.
 */
module load_model (
    input  wire logic [prot_pkg::NUM_CH-1:0] drive_on,
    input  wire logic [prot_pkg::NUM_CH-1:0] overload,
    input  wire logic [prot_pkg::NUM_CH-1:0] inrush,
    input  wire logic [prot_pkg::NUM_CH-1:0] shorted,
    output logic      [prot_pkg::NUM_CH-1:0] over_thresh,
    output logic      [prot_pkg::NUM_CH-1:0] above_lower,
    output logic      [prot_pkg::NUM_CH-1:0] short_detect
);
    timeunit 1ns;
    timeprecision 1ps;
    import prot_pkg::*;
    // an off switch carries no current, so every comparator drops
    assign over_thresh  = drive_on & overload;
    assign above_lower  = drive_on & (inrush | overload);
    assign short_detect = drive_on & shorted;
endmodule

/* File: prot_pkg.sv */
/*
 * shared types and constants for the two-channel switch protection logic.
 * assumes a single 100 MHz clock and comparator results that are already
 * digital levels, possibly asynchronous to that clock.
 */
package prot_pkg;
    localparam int NUM_CH      = 2;
    localparam int DUR_W       = 16;
    localparam int RETRY_W     = 4;
    localparam int CLK_MHZ     = 100;
    // switch-mode detector: an off edge within this time of the last one means modulation
    localparam int SWITCH_GAP_US   = 100;
    localparam int SWITCH_GAP_CYC  = SWITCH_GAP_US * CLK_MHZ;
    // cycles after the drive rises in which a short still counts as found at turn-on
    localparam int SHORT_WIN_CYC   = 5;
    localparam logic [1:0] SYNC_RESET = 2'h0;
    localparam logic [RETRY_W-1:0] RETRY_RESET = 4'h0;
    localparam logic [DUR_W-1:0]   DUR_RESET   = 16'h0000;

    // per-channel settings from software
    typedef struct packed {
        logic              load_profile_select;   // 0 lighting, 1 motor
        logic              retry_enable;
        logic [RETRY_W-1:0] retry_limit;
        logic [DUR_W-1:0]  window_width;          // overcurrent window width in cycles
        logic              delatch;               // one-cycle request
        logic              channel_drive_request; // hson level
    } ch_cfg_t;

    // per-channel analog comparator results
    typedef struct packed {
        logic over_thresh;   // above active threshold of the profile
        logic above_lower;   // above lower overcurrent level
        logic short_detect;
    } ch_cmp_t;

    typedef struct packed {
        logic current_trip;
        logic short_trip;
        logic drive_on;
        logic window_active;
    } ch_stat_t;
endpackage

/* File: switch_fault_protection.sv */
/*
 * fault latching and overcurrent profile logic for two high-side channels.
 * assumes comparator levels from the analog stage, software strobes from
 * the serial port logic, and one clock with an active-low async reset.
 */
// How it works
// - overcurrent turns the channel off, sets current_trip, pulls fault_flag_n low.
// - overcurrent is a threshold crossing or a motor-mode window held longer than its width.
// - while any window is active, sense is blanked and sense_valid_strobe_n stays high.
// - load_profile_select 0 picks lighting profile, 1 picks motor profile, per channel.
// - lighting restarts profile each turn-on; switch mode starts it only once.
// - motor mode opens its window when current exceeds the lower level.
// - with auto-retry, overcurrent latches only after all retries are spent.
// - sub-100% duty at modulation rate counts as switch mode.
// - switch mode counts only on-time in the window; window closes when over width.
// - delatch clears the counter; lighting auto-retry clears it too, motor not.
// - motor mode clears the counter at turn-off after a clean on-period.
// - in switch mode modulation never clears the counter; only delatch or lighting auto-retry does.
// - severe short at turn-on: off at once, short_trip; auto-retry with fault high while budget lasts, else fault low, latch.
// - supply-high with check on turns both off, fault low, sets supply_high_fault.
// - supply_high_fault clears on device_status_reg read once condition is gone.
// - with supply_high_check_off, only the warning flag is set.
// - supply-low turns both off, fault low, sets supply_low_fault.
// - supply-low clearing with request off releases fault; flag waits for turn-on.
// - with request on, channel returns after delatch, reset, request going off, or auto-retry; read clears flag.
// - auto-retry resumes as soon as supply-low disappears.
// - supply flags and settings are kept; overtemp reported only above supply-low.
// - latched faults clear on reset, logic-supply failure or read after delatch.
module switch_fault_protection
    import prot_pkg::*;
(
    input  wire logic                   SYS_CLK,
    input  wire logic                   RESETN,
    input  prot_pkg::ch_cfg_t           CH_CFG [prot_pkg::NUM_CH],
    input  wire logic [prot_pkg::NUM_CH-1:0] CMP_OVER_THRESH,
    input  wire logic [prot_pkg::NUM_CH-1:0] CMP_ABOVE_LOWER,
    input  wire logic [prot_pkg::NUM_CH-1:0] CMP_SHORT,
    input  wire logic                   CMP_SUPPLY_HIGH,
    input  wire logic                   CMP_SUPPLY_LOW,
    input  wire logic                   CMP_OVERTEMP,
    input  wire logic                   LOGIC_SUPPLY_FAIL,
    input  wire logic                   SUPPLY_HIGH_CHECK_OFF,
    input  wire logic                   STATUS_READ,
    input  wire logic                   FAULT_READ,
    output prot_pkg::ch_stat_t          CH_STAT [prot_pkg::NUM_CH],
    output logic                        SUPPLY_HIGH_FAULT,
    output logic                        SUPPLY_LOW_FAULT,
    output logic                        OVERTEMP_FAULT,
    output logic                        FAULT_FLAG_N,
    output logic                        SENSE_VALID_STROBE_N,
    output logic                        SENSE_BLANK
);
    typedef struct packed {
        logic [DUR_W-1:0]   dur;
        logic [RETRY_W-1:0] retries;
        logic [15:0]        gap;
        logic [2:0]         since_on;
        logic               on_prev;
        logic               oc_latched;
        logic               sc_latched;
        logic               lock_out;
        logic               profile_armed;
        logic               switch_mode;
        logic               clean_on;
        logic               window;
        logic               current_trip;
        logic               short_trip;
        logic               drive;
    } ch_state_t;

    typedef struct packed {
        ch_state_t [NUM_CH-1:0] ch;
        logic                   sh_flag;
        logic                   sl_flag;
        logic                   sl_hold_on;
        logic                   ot_flag;
        logic                   sl_prev;
    } state_t;

    localparam int NSYNC = 3 * NUM_CH + 4;

    state_t state;
    state_t next_state;
    logic   rst_meta;
    logic   rst_n;
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] sy;
    logic [NUM_CH-1:0] over_s;
    logic [NUM_CH-1:0] lower_s;
    logic [NUM_CH-1:0] short_s;
    logic   sup_high;
    logic   sup_low;
    logic   overtemp;
    logic   vdd_fail;

    // reset release through two flops
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    assign raw = {CMP_OVER_THRESH, CMP_ABOVE_LOWER, CMP_SHORT,
                  CMP_SUPPLY_HIGH, CMP_SUPPLY_LOW, CMP_OVERTEMP, LOGIC_SUPPLY_FAIL};

    sync2 #(.W(NSYNC)) u_sync (
        .clk   (SYS_CLK),
        .rst_n (rst_n),
        .d     (raw),
        .q     (sy)
    );

    assign over_s   = sy[NSYNC-1 -: NUM_CH];
    assign lower_s  = sy[NSYNC-1-NUM_CH -: NUM_CH];
    assign short_s  = sy[NSYNC-1-2*NUM_CH -: NUM_CH];
    assign sup_high = sy[3];
    assign sup_low  = sy[2];
    assign overtemp = sy[1];
    assign vdd_fail = sy[0];

    always_comb begin
        logic      global_off;
        logic      any_on;
        logic      turn_on;
        logic      turn_off;
        logic      oc_now;
        logic      motor;
        logic      sl_gone;
        logic      short_on;
        ch_state_t c;
        next_state = state;
        global_off = sup_low || (sup_high && !SUPPLY_HIGH_CHECK_OFF);
        any_on     = 1'b0;
        turn_on    = 1'b0;
        turn_off   = 1'b0;
        oc_now     = 1'b0;
        motor      = 1'b0;
        sl_gone    = state.sl_prev && !sup_low;
        short_on   = 1'b0;
        c          = '0;
        next_state.sl_prev = sup_low;

        for (int i = 0; i < NUM_CH; i++) begin
            c     = state.ch[i];
            motor = CH_CFG[i].load_profile_select;
            turn_on  = CH_CFG[i].channel_drive_request && !c.on_prev;
            turn_off = !CH_CFG[i].channel_drive_request && c.on_prev;
            c.on_prev = CH_CFG[i].channel_drive_request;
            // the synchronised short arrives a few cycles after the drive rises,
            // so a short window after turn-on stands in for the turn-on instant
            short_on = short_s[i] && c.drive
                       && (c.since_on < 3'(SHORT_WIN_CYC));

            // switch-mode detect: request falls again soon after the previous fall
            if (turn_off) begin
                c.switch_mode = (c.gap != 16'h0000);
                c.gap = 16'(SWITCH_GAP_CYC);
            end else if (c.gap != 16'h0000) begin
                c.gap = c.gap - 16'h0001;
            end else if (CH_CFG[i].channel_drive_request) begin
                c.switch_mode = 1'b0;
            end

            // lock out after supply-low while request is held on
            if (sup_low && CH_CFG[i].channel_drive_request) begin
                c.lock_out = 1'b1;
            end
            if (!CH_CFG[i].channel_drive_request && !sup_low) begin
                c.lock_out = 1'b0;
            end

            if (CH_CFG[i].delatch) begin
                c.dur        = DUR_RESET;
                c.oc_latched = 1'b0;
                c.sc_latched = 1'b0;
                c.lock_out   = 1'b0;
                c.retries    = RETRY_RESET;
                c.profile_armed = 1'b0;
            end

            // window opening
            if (motor) begin
                c.window = lower_s[i] && c.drive;
            end else if (turn_on && !(c.switch_mode && c.profile_armed)) begin
                c.window        = 1'b1;
                c.profile_armed = 1'b1;
                if (!c.switch_mode) begin
                    c.dur = DUR_RESET;
                end
            end

            // duration counting only while driven
            if (c.window && c.drive) begin
                c.dur = c.dur + 16'h0001;
            end
            if (!motor && c.window && c.dur > CH_CFG[i].window_width && !over_s[i]) begin
                c.window = 1'b0;
            end
            if (c.drive && (over_s[i] || (c.window && c.dur > CH_CFG[i].window_width))) begin
                oc_now = 1'b1;
            end else begin
                oc_now = 1'b0;
            end
            if (motor && c.window && oc_now) begin
                c.clean_on = 1'b0;
            end else if (turn_on) begin
                c.clean_on = 1'b1;
            end
            if (motor && turn_off && c.clean_on && !c.switch_mode) begin
                c.dur = DUR_RESET;
            end

            if (oc_now) begin
                c.current_trip = 1'b1;
            end
            if (short_on) begin
                c.short_trip = 1'b1;
            end

            // auto-retry budget; lighting retry restarts the counter
            if ((oc_now || short_on) && !c.oc_latched) begin
                if (CH_CFG[i].retry_enable && c.retries < CH_CFG[i].retry_limit) begin
                    c.retries = c.retries + 4'h1;
                    if (!motor) begin
                        c.dur = DUR_RESET;
                    end
                end else begin
                    c.oc_latched = 1'b1;
                end
                if (short_on) begin
                    c.sc_latched = !CH_CFG[i].retry_enable || c.oc_latched;
                end
            end
            if (sl_gone && CH_CFG[i].retry_enable) begin
                c.lock_out = 1'b0;
            end

            // fault bits clear on read once the cause is gone and delatched
            if (FAULT_READ && !c.oc_latched && !c.sc_latched && !oc_now) begin
                c.current_trip = 1'b0;
                c.short_trip   = 1'b0;
            end
            if (vdd_fail) begin
                c.current_trip = 1'b0;
                c.short_trip   = 1'b0;
                c.oc_latched   = 1'b0;
                c.sc_latched   = 1'b0;
            end

            c.drive = CH_CFG[i].channel_drive_request && !global_off && !c.lock_out
                      && !c.oc_latched && !c.sc_latched && !oc_now
                      && !short_on;
            // cycles since the drive rose, saturating
            if (!c.drive) begin
                c.since_on = 3'h0;
            end else if (c.since_on != 3'h7) begin
                c.since_on = c.since_on + 3'h1;
            end
            if (CH_CFG[i].channel_drive_request && c.drive) begin
                any_on = 1'b1;
            end
            next_state.ch[i] = c;
        end

        // supply-high flag, set wins over clear
        if (sup_high) begin
            next_state.sh_flag = 1'b1;
        end else if (STATUS_READ || vdd_fail) begin
            next_state.sh_flag = 1'b0;
        end

        // supply-low flag
        if (sup_low) begin
            next_state.sl_flag    = 1'b1;
            next_state.sl_hold_on = 1'b0;
        end else begin
            if (sl_gone) begin
                next_state.sl_hold_on = 1'b1;
                for (int i = 0; i < NUM_CH; i++) begin
                    if (CH_CFG[i].channel_drive_request) begin
                        next_state.sl_hold_on = 1'b0;
                    end
                end
            end
            if (state.sl_hold_on && any_on) begin
                next_state.sl_flag    = 1'b0;
                next_state.sl_hold_on = 1'b0;
            end else if ((STATUS_READ && !state.sl_hold_on) || vdd_fail) begin
                next_state.sl_flag = 1'b0;
            end
        end

        // overtemp reported only when supply is above the low threshold
        if (overtemp && !sup_low) begin
            next_state.ot_flag = 1'b1;
        end else if ((FAULT_READ && !overtemp) || vdd_fail) begin
            next_state.ot_flag = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    always_comb begin
        logic blank;
        logic fault;
        blank = 1'b0;
        fault = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            CH_STAT[i].current_trip  = state.ch[i].current_trip;
            CH_STAT[i].short_trip    = state.ch[i].short_trip;
            CH_STAT[i].drive_on      = state.ch[i].drive;
            CH_STAT[i].window_active = state.ch[i].window;
            blank = blank | state.ch[i].window;
            fault = fault | state.ch[i].oc_latched | state.ch[i].sc_latched
                    | (state.ch[i].current_trip & state.ch[i].on_prev & ~state.ch[i].drive);
        end
        fault = fault | state.sl_prev | (state.sh_flag & ~SUPPLY_HIGH_CHECK_OFF & sup_high)
                | state.ot_flag;
        SENSE_BLANK          = blank;
        SENSE_VALID_STROBE_N = blank;
        FAULT_FLAG_N         = ~fault;
        SUPPLY_HIGH_FAULT    = state.sh_flag;
        SUPPLY_LOW_FAULT     = state.sl_flag;
        OVERTEMP_FAULT       = state.ot_flag;
    end
endmodule

/* File: switch_fault_protection_tb.sv */
/*
 * self-checking bench for the switch protection block.
 * assumes the checker is bound by its own file and a 100 MHz clock.
 */
module switch_fault_protection_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import prot_pkg::*;
    typedef struct packed {
        logic sh, off, sl, ovl, sc, hf, lf, flag, drv, oc, sct;
    } row_t;
    localparam row_t    ROWS [6] = '{11'h00c, 11'h420, 11'h62c, 11'h110, 11'h082, 11'h041};
    localparam ch_cfg_t BASE     = '{load_profile_select: 1'h0, retry_enable: 1'h0, retry_limit: 4'h0,
                                     window_width: 16'h0020, delatch: 1'h0, channel_drive_request: 1'h0};
    logic              clk, rst_n, sh, sl, off, sread, fread, hf, lf, flag_n, strobe_n, blank;
    ch_cfg_t           cfg [NUM_CH];
    ch_stat_t          stat [NUM_CH];
    logic [NUM_CH-1:0] d_on, ovl, inr, shc, c_ovr, c_low, c_sc;
    int                errors, comparisons;
    assign d_on = {stat[1].drive_on, stat[0].drive_on};
    load_model i_load (.drive_on(d_on), .overload(ovl), .inrush(inr), .shorted(shc),
        .over_thresh(c_ovr), .above_lower(c_low), .short_detect(c_sc));
    switch_fault_protection i_dut (.SYS_CLK(clk), .RESETN(rst_n), .CH_CFG(cfg), .CMP_OVER_THRESH(c_ovr),
        .CMP_ABOVE_LOWER(c_low), .CMP_SHORT(c_sc), .CMP_SUPPLY_HIGH(sh), .CMP_SUPPLY_LOW(sl),
        .CMP_OVERTEMP(1'h0), .LOGIC_SUPPLY_FAIL(1'h0), .SUPPLY_HIGH_CHECK_OFF(off), .STATUS_READ(sread),
        .FAULT_READ(fread), .CH_STAT(stat), .SUPPLY_HIGH_FAULT(hf), .SUPPLY_LOW_FAULT(lf),
        .OVERTEMP_FAULT(), .FAULT_FLAG_N(flag_n), .SENSE_VALID_STROBE_N(strobe_n), .SENSE_BLANK(blank));
    task automatic check(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // waits past the edge so registered outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic req(input logic v);
        @(posedge clk);
        cfg[0].channel_drive_request <= v;
        cfg[1].channel_drive_request <= v;
    endtask
    // 0 status read, 1 fault read, 2 delatch of channel 0
    task automatic strobe(input int k);
        @(posedge clk);
        sread <= (k == 0);
        fread <= (k == 1);
        cfg[0].delatch <= (k == 2);
        @(posedge clk);
        sread <= 1'h0;
        fread <= 1'h0;
        cfg[0].delatch <= 1'h0;
    endtask
    task automatic do_reset;
        @(posedge clk);
        {sh, sl, off, sread, fread} <= 5'h00;
        {ovl, inr, shc} <= 6'h00;
        cfg[0] <= BASE;
        cfg[1] <= BASE;
        rst_n <= 1'h0;
        cyc(20);
        rst_n <= 1'h1;
        cyc(6);
    endtask
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        finish_test();
    end
    initial begin
        {rst_n, sh, sl, off, sread, fread} = 6'h00;
        {ovl, inr, shc} = 6'h00;
        cfg[0] = BASE;
        cfg[1] = BASE;
        errors = 0;
        comparisons = 0;
        do_reset();
        check(flag_n, 1'h1, "reset line");
        check(lf, 1'h0, "reset low flag");
        check(strobe_n, 1'h0, "reset strobe");
        for (int r = 0; r < 6; r++) begin
            do_reset();
            @(posedge clk);
            sh <= ROWS[r].sh;
            off <= ROWS[r].off;
            sl <= ROWS[r].sl;
            ovl[0] <= ROWS[r].ovl;
            shc[0] <= ROWS[r].sc;
            cyc(6);
            req(1'h1);
            cyc(12);
            check(hf, ROWS[r].hf, "high flag");
            check(lf, ROWS[r].lf, "low flag");
            check(flag_n, ROWS[r].flag, "fault line");
            check(stat[0].drive_on, ROWS[r].drv, "drive");
            check(stat[0].current_trip, ROWS[r].oc, "current trip");
            check(stat[0].short_trip, ROWS[r].sct, "short trip");
        end
        do_reset();
        @(posedge clk);
        sh <= 1'h1;
        cyc(10);
        sh <= 1'h0;
        cyc(10);
        check(hf, 1'h1, "high kept");
        strobe(0);
        cyc(2);
        check(hf, 1'h0, "high read");
        do_reset();
        req(1'h1);
        cyc(5);
        sl <= 1'h1;
        cyc(10);
        req(1'h0);
        sl <= 1'h0;
        cyc(10);
        check(flag_n, 1'h1, "low gone");
        check(lf, 1'h1, "low kept");
        req(1'h1);
        cyc(8);
        check(lf, 1'h0, "low on");
        do_reset();
        req(1'h1);
        cyc(5);
        sl <= 1'h1;
        cyc(10);
        sl <= 1'h0;
        cyc(10);
        check(stat[0].drive_on, 1'h0, "locked");
        strobe(2);
        req(1'h0);
        req(1'h1);
        cyc(6);
        check(stat[0].drive_on, 1'h1, "relit");
        strobe(0);
        cyc(2);
        check(lf, 1'h0, "low read");
        do_reset();
        req(1'h1);
        cyc(5);
        ovl[0] <= 1'h1;
        for (int i = 0; i < 50 && stat[0].current_trip !== 1'h1; i++) cyc(1);
        if (stat[0].current_trip !== 1'h1) begin
            errors++;
            finish_test();
        end
        check(flag_n, 1'h0, "oc line");
        ovl[0] <= 1'h0;
        strobe(2);
        strobe(1);
        cyc(2);
        check(stat[0].current_trip, 1'h0, "oc read");
        check(flag_n, 1'h1, "line back");
        do_reset();
        @(posedge clk);
        cfg[0].load_profile_select <= 1'h1;
        req(1'h1);
        cyc(8);
        check(stat[0].window_active, 1'h0, "motor idle");
        inr[0] <= 1'h1;
        cyc(6);
        check(stat[0].window_active, 1'h1, "motor window");
        check(strobe_n, 1'h1, "blanked");
        do_reset();
        req(1'h1);
        cyc(4);
        check(stat[0].window_active, 1'h1, "light window");
        finish_test();
    end
endmodule

/* File: sync2.sv */
/*
 * two-flop synchroniser for a bus of independent levels.
 * assumes each bit is a slowly changing level from another domain.
 */
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] stage1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            q      <= '0;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end
endmodule
